// *** dv/rnp_board_model.sv ***
// board side: open-drain reset line with pull-up and nmi source
`timescale 1ns/10ps
module rnp_board_model (
   // bench commands
   input wire logic hwRst,
   input wire logic nmiLow,
   // device side
   input wire logic resetInputPinOe_b,
   output logic resetInputPin,
   output logic nmiPin
);
   // wired-and: board and device may only pull low, pull-up otherwise
   assign resetInputPin = !hwRst && resetInputPinOe_b;
   // nmi rests high when unused
   assign nmiPin = !nmiLow;
endmodule

// *** dv/rnp_checker.sv ***
// assertions for the reset, nmi and power-down control block
`timescale 1ns/10ps
module rnp_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pins
   input wire logic resetInputPin,
   input wire logic resetInputPinOe_b,
   input wire logic nmiPin,
   input wire logic resetIndicationOut,
   // core events
   input wire logic softResetReq,
   input wire logic watchdogResetReq,
   input wire logic endOfInitInstr,
   input wire logic powerDownInstr,
   // status
   input wire logic coreResetActive,
   input wire logic bidirResetEnable,
   input wire logic watchdogResetFlag,
   input wire logic portZeroSample,
   input wire logic nmiTrapReq,
   input wire logic powerDownMode
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // core reset sources; the pin source is seen through the wire
   sequence s_src; softResetReq || watchdogResetReq; endsequence
   // three samples so the two-stage synchroniser has settled
   sequence s_nmiLo; !nmiPin [*3]; endsequence
   sequence s_nmiHi; nmiPin [*3]; endsequence
   // a fall, then no reset while it crosses the synchroniser
   sequence s_nmiFall;
      ($fell(nmiPin) && !coreResetActive) ##1 !coreResetActive [*2];
   endsequence
   property p_src; s_src |=> !resetIndicationOut && !bidirResetEnable;
   endproperty
   a_src: assert property (p_src)
      else $error("reset not shown");
   property p_hold;
      !resetIndicationOut && !endOfInitInstr |=> !resetIndicationOut;
   endproperty
   a_hold: assert property (p_hold)
      else $error("early release");
   property p_nmi; s_nmiFall |=> nmiTrapReq;
   endproperty
   a_nmi: assert property (p_nmi)
      else $error("no nmi request");
   // a request lasts one cycle, so one fall never counts twice
   property p_nmiOnce; nmiTrapReq |=> !nmiTrapReq;
   endproperty
   a_nmiOnce: assert property (p_nmiOnce)
      else $error("nmi request repeated");
   property p_pd;
      s_nmiLo ##0 (powerDownInstr && resetIndicationOut) |=> powerDownMode;
   endproperty
   a_pd: assert property (p_pd)
      else $error("no power-down");
   property p_pdIgn;
      s_nmiHi ##0 (powerDownInstr && !powerDownMode) |=> !powerDownMode;
   endproperty
   a_pdIgn: assert property (p_pdIgn)
      else $error("power-down taken");
   property p_lock; resetIndicationOut && resetInputPin && !softResetReq &&
      !watchdogResetReq |=> $stable(bidirResetEnable);
   endproperty
   a_lock: assert property (p_lock)
      else $error("bidir changed");
   property p_oe; s_src ##0 bidirResetEnable |=>
      (!resetInputPinOe_b && portZeroSample) ##1 !resetInputPinOe_b [*2];
   endproperty
   a_oe: assert property (p_oe)
      else $error("pin not pulled");
   property p_wdt; watchdogResetReq && bidirResetEnable |=>
      !watchdogResetFlag [*6];
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog flag set");
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the reset, nmi and power-down control block
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hwRst = 1'b0;
   logic nmiLow = 1'b0;
   logic bootPin = 1'b1;
   logic [6:0] ev = 7'h00;
   logic b, eo, ew, bp, eb;
   logic [1:0] k;
   wire rip, nmiPin, pinOe_b, ind, cra, bre, wrf, trp, pdm, bls, pzs;
   int n_errors = 0;
   int n_compared = 0;
   int nTrap = 0;
   int cyc = 0;
   // sequence length given to the design, short to keep the run brief
   localparam int SEQ = 4;
   // bidir, kind (0 soft 1 watchdog 2 pin), oe_b, watchdog flag,
   // boot pin level, loader select expected after the reset
   logic [6:0] rows [5] = '{7'h08, 7'h1C, 7'h41, 7'h52, 7'h29};
   rnp_reset_ctrl #(.SEQ_CYCLES(SEQ)) u_rnp_reset_ctrl (.clk(clk),
      .rst_b(rst_b), .resetInputPin(rip), .resetInputPinOut(),
      .resetInputPinOe_b(pinOe_b), .nmiPin(nmiPin),
      .bootSelectPin(bootPin), .resetIndicationOut(ind),
      .softResetReq(ev[0]),
      .watchdogResetReq(ev[1]), .endOfInitInstr(ev[2]),
      .powerDownInstr(ev[3]), .wakeFromPowerDown(ev[4]),
      .sysCfgWrite(ev[5]), .sysCfgBidirIn(ev[6]), .coreResetActive(cra),
      .bidirResetEnable(bre), .watchdogResetFlag(wrf),
      .bootLoaderSelect(bls), .portZeroSample(pzs), .nmiTrapReq(trp),
      .powerDownMode(pdm));
   rnp_board_model u_rnp_board_model (.hwRst(hwRst), .nmiLow(nmiLow),
      .resetInputPinOe_b(pinOe_b), .resetInputPin(rip), .nmiPin(nmiPin));
   task automatic chk(input string n, input logic e, input logic s);
      n_compared++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", n, e, s);
      end
   endtask
   // one-cycle event, then a quiet cycle so events never merge
   task automatic pulse(input logic [6:0] v);
      @(negedge clk) ev = v;
      @(negedge clk) ev = 7'h00;
   endtask
   // called right after the last source edge; counts the sequence length
   task automatic seqWait;
      int i;
      for (i = 0; i < 30 && cra !== 1'b0; i++) @(negedge clk);
      chk("cra", 1'b0, cra);
      chk("len", 1'b1, i == SEQ);
   endtask
   task automatic finish_test;
      if (n_errors == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial forever #25 clk = ~clk;
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 4000) begin
         n_errors++;
         finish_test;
      end
   end
   // requests counted away from the edge that launches them
   always @(negedge clk) begin
      if (trp === 1'b1) nTrap++;
   end
   initial begin
      repeat (16) @(negedge clk);
      chk("ind", 1'b0, ind);
      chk("bre", 1'b0, bre);
      rst_b = 1'b1;
      seqWait;
      for (int i = 0; i < 5; i++) begin
         {b, k, eo, ew, bp, eb} = rows[i];
         bootPin = bp;
         pulse({b, 6'h20});
         pulse(7'h04);
         chk("ind", 1'b1, ind);
         chk("bre", b, bre);
         if (k != 2'h2) pulse({5'h00, k[0], !k[0]});
         else begin
            hwRst = 1'b1;
            @(negedge clk);
         end
         chk("ind", 1'b0, ind);
         chk("cra", 1'b1, cra);
         chk("oe", eo, pinOe_b);
         chk("bre", 1'b0, bre);
         chk("pzs", b | k[1], pzs);
         chk("boot", eb, bls);
         // the pin is held over a second edge, the sequence restarts there
         if (k == 2'h2) @(negedge clk) hwRst = 1'b0;
         seqWait;
         chk("wdt", ew, wrf);
      end
      pulse(7'h04);
      pulse(7'h60);
      chk("bre", 1'b0, bre);
      nmiLow = 1'b1;
      repeat (5) @(negedge clk);
      chk("trap", 1'b1, nTrap == 1);
      pulse(7'h08);
      chk("pdm", 1'b1, pdm);
      pulse(7'h10);
      chk("pdm", 1'b0, pdm);
      nmiLow = 1'b0;
      repeat (4) @(negedge clk);
      pulse(7'h08);
      chk("pdm", 1'b0, pdm);
      chk("trap", 1'b1, nTrap == 1);
      rst_b = 1'b0;
      #1 chk("ind", 1'b0, ind);
      chk("cra", 1'b1, cra);
      chk("oe", 1'b1, pinOe_b);
      finish_test;
   end
endmodule
bind rnp_reset_ctrl rnp_checker u_rnp_checker (.*);

// *** hw/rnp_nmi_edge.sv ***
// nmi pin synchroniser and falling edge detector
`timescale 1ns/10ps
module rnp_nmi_edge (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pin side
   input wire logic nmiPin,
   // core side
   output logic nmiLevel,
   output logic nmiFall
);
   logic sync1_q;
   logic sync2_q;
   logic last_q;

   // two stage synchroniser; idle level is high, matching the pullup
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         last_q <= 1'b1;
      end else begin
         sync1_q <= nmiPin;
         sync2_q <= sync1_q;
         last_q <= sync2_q;
      end
   end

   // one pulse per high to low transition
   assign nmiFall = last_q & ~sync2_q;
   assign nmiLevel = sync2_q;
endmodule

// *** hw/rnp_reset_ctrl.sv ***
// reset indication, nmi trap request and power-down entry control
`timescale 1ns/10ps
// How it works
// - indication driven low during hardware, software or watchdog reset
// - indication stays low after reset until end-of-init instruction executes
// - nmi pin falling edge raises the nmi trap request to the cpu, except while core reset is active
// - power-down instruction with nmi pin low after end-of-init enters power-down mode
// - power-down instruction with nmi pin high is ignored
// - bidirectional reset enable cannot change after end-of-init
// - every reset clears the bidirectional reset enable
// - a watchdog reset taken with bidirectional reset on leaves the watchdog reset flag zero
// - bidir mode: soft resets sample port zero and boot select
// - bidir reset pulls reset input low for whole internal sequence
module rnp_reset_ctrl import rnp_pkg::*; #(
   parameter int SEQ_CYCLES = RESET_SEQ_CYC
) (
   // clock and power-on reset
   input wire logic clk,
   input wire logic rst_b,
   // board pins, reset input is open drain
   input wire logic resetInputPin,
   output logic resetInputPinOut,
   output logic resetInputPinOe_b,
   input wire logic nmiPin,
   input wire logic bootSelectPin,
   output logic resetIndicationOut,
   // core events
   input wire logic softResetReq,
   input wire logic watchdogResetReq,
   input wire logic endOfInitInstr,
   input wire logic powerDownInstr,
   input wire logic wakeFromPowerDown,
   // system config write port
   input wire logic sysCfgWrite,
   input wire logic sysCfgBidirIn,
   // core side status
   output logic coreResetActive,
   output logic bidirResetEnable,
   output logic watchdogResetFlag,
   output logic bootLoaderSelect,
   output logic portZeroSample,
   output logic nmiTrapReq,
   output logic powerDownMode
);
   rnp_state_t state_q;
   logic [SEQ_CNT_W-1:0] seqCnt_q;
   logic pinOe_q;
   logic reset_indication_out_q;
   logic bidir_q;
   logic wdtFlag_q;
   logic boot_q;
   logic sample_q;
   logic nmiReq_q;
   logic pd_q;
   logic coreRst_q;
   logic nmiLevel;
   logic nmiFall;
   logic softSrc;
   logic anySrc;
   logic hwSrc;

   rnp_nmi_edge u_nmi (
      .clk(clk),
      .rst_b(rst_b),
      .nmiPin(nmiPin),
      .nmiLevel(nmiLevel),
      .nmiFall(nmiFall)
   );

   // a low reset input is only a hardware reset when we are not the one
   // pulling it; otherwise our own bidir pulse would retrigger forever
   assign hwSrc = ~resetInputPin & pinOe_q;
   assign softSrc = softResetReq | watchdogResetReq;
   assign anySrc = hwSrc | softSrc;

   // reset sequencer: reset, waiting for end-of-init, running, power-down
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_RESET;
         seqCnt_q <= SEQ_CNT_RST;
      end else if (anySrc) begin
         state_q <= ST_RESET;
         seqCnt_q <= SEQ_CNT_RST;
      end else begin
         unique case (state_q)
            ST_RESET: begin
               if (seqCnt_q == SEQ_CNT_W'(SEQ_CYCLES - 1)) begin
                  state_q <= ST_INIT;
               end else begin
                  seqCnt_q <= seqCnt_q + 1'b1;
               end
            end
            ST_INIT: begin
               if (endOfInitInstr) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               // power down only taken with the nmi pin held low
               if (powerDownInstr && !nmiLevel) begin
                  state_q <= ST_POWERDOWN;
               end
            end
            ST_POWERDOWN: begin
               if (wakeFromPowerDown) begin
                  state_q <= ST_RUN;
               end
            end
         endcase
      end
   end

   // indication low from recognition cycle until end-of-init
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reset_indication_out_q <= 1'b0;
         coreRst_q <= 1'b1;
      end else begin
         reset_indication_out_q <= !(anySrc || state_q == ST_RESET ||
            (state_q == ST_INIT && !endOfInitInstr));
         coreRst_q <= anySrc || (state_q == ST_RESET &&
            seqCnt_q != SEQ_CNT_W'(SEQ_CYCLES - 1));
      end
   end

   // open drain pull of reset input across the internal sequence
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pinOe_q <= 1'b1;
      end else if (softSrc && bidir_q) begin
         pinOe_q <= 1'b0;
      end else if (state_q == ST_RESET && !softSrc &&
            seqCnt_q == SEQ_CNT_W'(SEQ_CYCLES - 1)) begin
         pinOe_q <= 1'b1;
      end
   end

   // bidir enable: cleared by any reset, frozen after end-of-init
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bidir_q <= BIDIR_RST_VAL;
      end else if (anySrc) begin
         bidir_q <= BIDIR_RST_VAL;
      end else if (sysCfgWrite && state_q != ST_RUN &&
            state_q != ST_POWERDOWN) begin
         bidir_q <= sysCfgBidirIn;
      end
   end

   // reset cause and port zero sampling; bidir decided at the source cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wdtFlag_q <= 1'b0;
         sample_q <= 1'b1;
         boot_q <= 1'b0;
      end else begin
         sample_q <= 1'b0;
         if (anySrc) begin
            // bidir mode hides watchdog cause
            wdtFlag_q <= watchdogResetReq & ~bidir_q & ~hwSrc;
            // soft resets sample port zero only in bidir mode
            if (hwSrc || bidir_q) begin
               sample_q <= 1'b1;
               boot_q <= ~bootSelectPin;
            end
         end
      end
   end

   // nmi trap request pulse and power-down status
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nmiReq_q <= 1'b0;
         pd_q <= 1'b0;
      end else begin
         nmiReq_q <= nmiFall & ~coreRst_q;
         pd_q <= (state_q == ST_RUN && powerDownInstr && !nmiLevel &&
            !anySrc) || (state_q == ST_POWERDOWN && !wakeFromPowerDown &&
            !anySrc);
      end
   end

   assign resetInputPinOut = 1'b0;
   assign resetInputPinOe_b = pinOe_q;
   assign resetIndicationOut = reset_indication_out_q;
   assign coreResetActive = coreRst_q;
   assign bidirResetEnable = bidir_q;
   assign watchdogResetFlag = wdtFlag_q;
   assign bootLoaderSelect = boot_q;
   assign portZeroSample = sample_q;
   assign nmiTrapReq = nmiReq_q;
   assign powerDownMode = pd_q;
endmodule

// *** pkg/rnp_pkg.sv ***
// constants and types for the reset, nmi and power-down control block
package rnp_pkg;
   // internal reset sequence length in cpu clocks
   localparam int RESET_SEQ_NS = 5000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_SEQ_CYC = (RESET_SEQ_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int SEQ_CNT_W = 8;
   // reset source codes held for software
   localparam logic [1:0] SRC_HW = 2'h0;
   localparam logic [1:0] SRC_SW = 2'h1;
   localparam logic [1:0] SRC_WDT = 2'h2;
   // reset values
   localparam logic BIDIR_RST_VAL = 1'b0;
   localparam logic [SEQ_CNT_W-1:0] SEQ_CNT_RST = 8'h00;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_INIT = 2'b01,
      ST_RUN = 2'b10,
      ST_POWERDOWN = 2'b11
   } rnp_state_t;
endpackage
